// file: rtl/tmr_pkg.sv
// constants for the 8-bit timer with shared prescaler
// assumes a 32-bit AHB-Lite register bus, one word per register
package tmr_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 8;
   localparam int PRESC_WIDTH = 10;
   localparam int CS_W = 3;
   localparam int TAP_N = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_SFIO = 8'h10;

   // field positions
   localparam int OVF_IE_BIT = 0;
   localparam int OVF_FLAG_BIT = 0;
   localparam int PSR_BIT = 0;

   // reset values, count limit and count step
   localparam logic [CS_W-1:0] RST_CS = 3'h0;
   localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;
   localparam logic [CNT_W-1:0] RST_MASK = 8'h00;
   localparam logic [CNT_W-1:0] COUNT_MAX = 8'hFF;
   localparam logic [CNT_W-1:0] COUNT_ONE = 8'h01;

   // clock select codes
   localparam logic [CS_W-1:0] CS_STOP = 3'h0;
   localparam logic [CS_W-1:0] CS_CLK1 = 3'h1;
   localparam logic [CS_W-1:0] CS_DIV8 = 3'h2;
   localparam logic [CS_W-1:0] CS_DIV64 = 3'h3;
   localparam logic [CS_W-1:0] CS_DIV256 = 3'h4;
   localparam logic [CS_W-1:0] CS_DIV1024 = 3'h5;
   localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
   localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;

   // prescaler tap widths: low bits all ones marks the tap pulse
   localparam int TAP8_W = 3;
   localparam int TAP64_W = 6;
   localparam int TAP256_W = 8;
   localparam int TAP1024_W = 10;

   // ahb-lite
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage

// file: rtl/tmr_prescaler.sv
// free-running shared prescaler with four divide taps
// assumes reset pulse is one clk cycle from the register block
`timescale 1ns/1ps
module tmr_prescaler #(
   parameter int WIDTH = tmr_pkg::PRESC_WIDTH
) (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, active high
   input wire logic prescClear, // one-cycle prescaler reset
   output logic [WIDTH-1:0] prescCount, // running prescaler value
   output logic [tmr_pkg::TAP_N-1:0] tapPulse // div 8,64,256,1024 pulses
);
   localparam int TAP_W [tmr_pkg::TAP_N] = '{tmr_pkg::TAP8_W, tmr_pkg::TAP64_W,
      tmr_pkg::TAP256_W, tmr_pkg::TAP1024_W};
   logic [WIDTH-1:0] next_prescCount;

   // counts regardless of any clock select
   always_comb begin
      next_prescCount = WIDTH'(prescCount + 1'b1);
      if (prescClear) begin
         next_prescCount = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prescCount <= '0;
      end else begin
         prescCount <= next_prescCount;
      end
   end

   genvar g;
   generate
      for (g = 0; g < tmr_pkg::TAP_N; g++) begin : gTap
         assign tapPulse[g] = &prescCount[TAP_W[g]-1:0];
      end
   endgenerate
endmodule

// file: rtl/tmr_timer8.sv
// 8-bit up counter with clock select, overflow flag and ahb-lite registers
// assumes single-word ahb-lite transfers and one synchronous clock
//
// How it works
// - three-bit clock select, zero stops counter
// - codes 1-5: clock, div 8/64/256/1024
// - code 6 falling, 7 rising external edges
// - external pin counts even when driven output
// - count register readable and writable any time
// - irq needs enable bit, global bit, flag
// - overflow sets flag, vector execution clears it
// - writing one clears flag, zero ignored
// - prescaler free running, shared, per-timer tap
// - first prescaled count within 1..N cycles
// - prescaler reset bit resets, self-clears
// - prescaler reset bit always reads zero
// - pin synchronized on clock before edge detection
// - pin edge to count 2-3 cycles
// - external pulses bypass prescaler
// - increment by one, wrap, flag on zero
// - software count write beats counting
`timescale 1ns/1ps
module tmr_timer8 #(
   parameter int PRESC_W = tmr_pkg::PRESC_WIDTH
) (
   input wire logic clk, // system clock, 125 MHz
   input wire logic srst, // sync reset, active high
   input wire logic hsel, // ahb slave select
   input wire logic [tmr_pkg::DATA_W-1:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [tmr_pkg::DATA_W-1:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response
   output logic [tmr_pkg::DATA_W-1:0] hrdata, // ahb read data
   input wire logic externalCountPin, // external count input
   input wire logic cpuGlobalIntEnable, // cpu global interrupt bit
   input wire logic overflowVectorAck, // pulse: overflow vector executed
   output logic overflowIrq, // overflow interrupt request
   output logic [PRESC_W-1:0] sharedPrescale // prescaler state for other timer
);
   logic [tmr_pkg::CS_W-1:0] clockSelect, next_clockSelect;
   logic [tmr_pkg::CNT_W-1:0] counterValue, next_counterValue;
   logic [tmr_pkg::CNT_W-1:0] timerMask, next_timerMask;
   logic overflowFlag, next_overflowFlag;
   logic next_overflowIrq;
   logic prescClear, next_prescClear;
   logic dpWrite, next_dpWrite;
   logic [tmr_pkg::ADDR_W-1:0] dpAddr, next_dpAddr;
   logic [tmr_pkg::DATA_W-1:0] next_hrdata;
   logic pinSync1, pinSync2, pinSync3;
   logic [tmr_pkg::TAP_N-1:0] tapPulse;
   logic timerClockEnable;
   logic addrPhase;
   logic wrCtrl, wrCount, wrMask, wrFlags, wrSfio;
   logic overflowSet, overflowClear;
   logic next_pinSync1, next_pinSync2, next_pinSync3;
   logic [PRESC_W:0] tickWait, next_tickWait, tickLimit;
   localparam logic [PRESC_W:0] TICK_UNIT = (PRESC_W+1)'(tmr_pkg::COUNT_ONE);

   tmr_prescaler #(
      .WIDTH(PRESC_W)
   ) uPresc (
      .clk(clk),
      .srst(srst),
      .prescClear(prescClear),
      .prescCount(sharedPrescale),
      .tapPulse(tapPulse)
   );

   // bus address phase capture
   assign addrPhase = hsel && htrans[1] && hready;

   always_comb begin
      next_dpWrite = 1'b0;
      next_dpAddr = dpAddr;
      next_hrdata = hrdata;
      if (hready) begin
         next_dpWrite = addrPhase && hwrite;
         next_hrdata = tmr_pkg::RD_ZERO;
      end
      if (addrPhase) begin
         next_dpAddr = haddr[tmr_pkg::ADDR_W-1:0];
         if (!hwrite) begin
            unique case (haddr[tmr_pkg::ADDR_W-1:0])
               tmr_pkg::OFF_CTRL: next_hrdata = {29'h0000_0000, clockSelect};
               tmr_pkg::OFF_COUNT: next_hrdata = {24'h00_0000, counterValue};
               tmr_pkg::OFF_MASK: next_hrdata = {24'h00_0000, timerMask};
               tmr_pkg::OFF_FLAGS: next_hrdata = {31'h0000_0000, overflowFlag};
               tmr_pkg::OFF_SFIO: next_hrdata = tmr_pkg::RD_ZERO;
               default: next_hrdata = tmr_pkg::RD_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dpWrite <= 1'b0;
         dpAddr <= '0;
         hrdata <= tmr_pkg::RD_ZERO;
         hreadyout <= 1'b1;
         hresp <= tmr_pkg::HRESP_OKAY;
      end else begin
         dpWrite <= next_dpWrite;
         dpAddr <= next_dpAddr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= tmr_pkg::HRESP_OKAY;
      end
   end

   // data phase write strobes
   assign wrCtrl = dpWrite && (dpAddr == tmr_pkg::OFF_CTRL);
   assign wrCount = dpWrite && (dpAddr == tmr_pkg::OFF_COUNT);
   assign wrMask = dpWrite && (dpAddr == tmr_pkg::OFF_MASK);
   assign wrFlags = dpWrite && (dpAddr == tmr_pkg::OFF_FLAGS);
   assign wrSfio = dpWrite && (dpAddr == tmr_pkg::OFF_SFIO);

   // pin synchronizer, stage one feeds stage two only
   // a rising-edge flop stands in for the high-phase latch
   // so pin changes early in a cycle keep the edge delay in window
   always_comb begin
      next_pinSync1 = externalCountPin;
      next_pinSync2 = pinSync1;
      next_pinSync3 = pinSync2;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinSync3 <= 1'b0;
      end else begin
         pinSync1 <= next_pinSync1;
         pinSync2 <= next_pinSync2;
         pinSync3 <= next_pinSync3;
      end
   end

   // timer clock enable select
   always_comb begin
      unique case (clockSelect)
         tmr_pkg::CS_STOP: timerClockEnable = 1'b0;
         tmr_pkg::CS_CLK1: timerClockEnable = 1'b1;
         tmr_pkg::CS_DIV8: timerClockEnable = tapPulse[0];
         tmr_pkg::CS_DIV64: timerClockEnable = tapPulse[1];
         tmr_pkg::CS_DIV256: timerClockEnable = tapPulse[2];
         tmr_pkg::CS_DIV1024: timerClockEnable = tapPulse[3];
         tmr_pkg::CS_EXT_FALL: timerClockEnable = !pinSync2 && pinSync3;
         tmr_pkg::CS_EXT_RISE: timerClockEnable = pinSync2 && !pinSync3;
      endcase
   end

   // wait on a prescaled tap since select, tick or prescaler reset
   always_comb begin
      unique case (clockSelect)
         tmr_pkg::CS_DIV8: tickLimit = TICK_UNIT << tmr_pkg::TAP8_W;
         tmr_pkg::CS_DIV64: tickLimit = TICK_UNIT << tmr_pkg::TAP64_W;
         tmr_pkg::CS_DIV256: tickLimit = TICK_UNIT << tmr_pkg::TAP256_W;
         tmr_pkg::CS_DIV1024: tickLimit = TICK_UNIT << tmr_pkg::TAP1024_W;
         default: tickLimit = '0;
      endcase
      next_tickWait = (PRESC_W+1)'(tickWait + 1'b1);
      if (tickLimit == '0 || timerClockEnable || prescClear || wrCtrl) begin
         next_tickWait = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tickWait <= '0;
      end else begin
         tickWait <= next_tickWait;
      end
   end

   assign overflowSet = timerClockEnable && !wrCount && (counterValue == tmr_pkg::COUNT_MAX);
   assign overflowClear = overflowVectorAck
      || (wrFlags && hwdata[tmr_pkg::OVF_FLAG_BIT]);

   always_comb begin
      next_clockSelect = clockSelect;
      next_counterValue = counterValue;
      next_timerMask = timerMask;
      next_overflowFlag = overflowFlag;
      if (wrCtrl) begin
         next_clockSelect = hwdata[tmr_pkg::CS_W-1:0];
      end
      if (wrMask) begin
         next_timerMask = hwdata[tmr_pkg::CNT_W-1:0];
      end
      if (timerClockEnable) begin
         next_counterValue = tmr_pkg::CNT_W'(counterValue + tmr_pkg::COUNT_ONE);
      end
      if (wrCount) begin
         next_counterValue = hwdata[tmr_pkg::CNT_W-1:0];
      end
      if (overflowClear) begin
         next_overflowFlag = 1'b0;
      end
      if (overflowSet) begin
         next_overflowFlag = 1'b1;
      end
      next_overflowIrq = overflowFlag && cpuGlobalIntEnable
         && timerMask[tmr_pkg::OVF_IE_BIT];
      next_prescClear = wrSfio && hwdata[tmr_pkg::PSR_BIT];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clockSelect <= tmr_pkg::RST_CS;
         counterValue <= tmr_pkg::RST_COUNT;
         timerMask <= tmr_pkg::RST_MASK;
         overflowFlag <= 1'b0;
         overflowIrq <= 1'b0;
         prescClear <= 1'b0;
      end else begin
         clockSelect <= next_clockSelect;
         counterValue <= next_counterValue;
         timerMask <= next_timerMask;
         overflowFlag <= next_overflowFlag;
         overflowIrq <= next_overflowIrq;
         prescClear <= next_prescClear;
      end
   end

   // checks
   chk_stop_hold: assert property (@(posedge clk) disable iff (srst)
      (clockSelect == tmr_pkg::CS_STOP && !wrCount) |=> $stable(counterValue))
      else $error("counter moved while stopped");

   chk_count_step: assert property (@(posedge clk) disable iff (srst)
      (timerClockEnable && !wrCount) |=> counterValue == 8'($past(counterValue) + 8'h01))
      else $error("counter did not step by one");

   chk_write_prio: assert property (@(posedge clk) disable iff (srst)
      wrCount |=> counterValue == $past(hwdata[7:0]))
      else $error("count write lost");

   chk_ovf_set: assert property (@(posedge clk) disable iff (srst)
      (timerClockEnable && !wrCount && counterValue == 8'hFF)
      |=> (overflowFlag && counterValue == 8'h00))
      else $error("overflow flag not set on wrap");

   chk_flag_clear: assert property (@(posedge clk) disable iff (srst)
      (wrFlags && hwdata[0] && !overflowSet) |=> !overflowFlag)
      else $error("flag not cleared by write one");

   chk_flag_keep: assert property (@(posedge clk) disable iff (srst)
      (overflowFlag && !overflowVectorAck && !(wrFlags && hwdata[0])) |=> overflowFlag)
      else $error("flag lost without clear");

   chk_irq_gate: assert property (@(posedge clk) disable iff (srst)
      ##1 overflowIrq == $past(overflowFlag && cpuGlobalIntEnable && timerMask[0]))
      else $error("irq does not follow gating");

   chk_psr_read: assert property (@(posedge clk) disable iff (srst)
      (addrPhase && !hwrite && haddr[7:0] == 8'h10) |=> hrdata == 32'h0000_0000)
      else $error("prescaler reset bit read nonzero");

   chk_presc_reset: assert property (@(posedge clk) disable iff (srst)
      (wrSfio && hwdata[0]) |=> ##1 (sharedPrescale == '0 && !prescClear))
      else $error("prescaler not reset");

   chk_ext_delay: assert property (@(posedge clk) disable iff (srst)
      ($rose(externalCountPin) && clockSelect == 3'h7 ##1 $stable(externalCountPin)
      ##1 clockSelect == 3'h7) |-> timerClockEnable)
      else $error("external edge not counted in time");

   chk_div8_tick: assert property (@(posedge clk) disable iff (srst)
      (clockSelect == 3'h2 && timerClockEnable && !prescClear)
      |=> !timerClockEnable [*7])
      else $error("div 8 tap too fast");

   chk_first_tick: assert property (@(posedge clk) disable iff (srst)
      (tickLimit != '0) |-> tickWait < tickLimit)
      else $error("prescaled tick came too late");

   chk_ext_fall: assert property (@(posedge clk) disable iff (srst)
      ($fell(externalCountPin) && clockSelect == 3'h6 ##1 $stable(externalCountPin)
      ##1 clockSelect == 3'h6) |-> timerClockEnable)
      else $error("falling edge not counted in time");

   chk_ext_single: assert property (@(posedge clk) disable iff (srst)
      (clockSelect == 3'h7 && timerClockEnable) |=> !(clockSelect == 3'h7 && timerClockEnable))
      else $error("one edge gave two counts");

   chk_vector_clear: assert property (@(posedge clk) disable iff (srst)
      (overflowVectorAck && !overflowSet) |=> !overflowFlag)
      else $error("vector did not clear flag");

   chk_irq_mask: assert property (@(posedge clk) disable iff (srst)
      (!timerMask[0] || !cpuGlobalIntEnable) |=> !overflowIrq)
      else $error("irq raised while masked");

   cov_overflow: cover property (@(posedge clk) disable iff (srst) overflowSet);
   cov_ext_fall: cover property (@(posedge clk) disable iff (srst)
      clockSelect == 3'h6 && timerClockEnable);
   cov_presc_clear: cover property (@(posedge clk) disable iff (srst) prescClear);
   cov_irq: cover property (@(posedge clk) disable iff (srst) $rose(overflowIrq));
   cov_div1024: cover property (@(posedge clk) disable iff (srst)
      clockSelect == 3'h5 && timerClockEnable);
endmodule

// file: tb/tmr_pin_source.sv
// partner: pulse source on the external count pin
// assumes start is held high across one clk edge to begin a burst
`timescale 1ns/1ps
module tmr_pin_source (
   input wire logic clk, // system clock
   input wire logic start, // begin a burst
   input wire logic [7:0] pulses, // pulses in the burst
   output logic pin, // external count pin
   output logic busy // burst in progress
);
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (start === 1'b1) begin
            busy = 1'b1;
            repeat (pulses) begin
               // edges land off the clock edge, two cycles per half period
               #3 pin = 1'b1;
               repeat (2) @(posedge clk);
               #3 pin = 1'b0;
               repeat (2) @(posedge clk);
            end
            // pin rests low between bursts
            busy = 1'b0;
         end
      end
   end
endmodule

// file: tb/tb_tmr_timer8.sv
// bench for tmr_timer8: register reads and counts against a bench model
// assumes tmr_pin_source drives the count pin
`timescale 1ns/1ps
module tb_tmr_timer8;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic globalInt = 1'b0;
   logic vectorAck = 1'b0;
   logic start = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, irq, pin, busy;
   logic [7:0] pulses = 8'h00;
   logic [7:0] lfsr = 8'h25;
   logic [9:0] presc;
   int nErrors = 0;
   int cmpCount = 0;
   int n;
   int expCount;
   int modelQ[$];
   always #4 clk = ~clk;
   tmr_timer8 i_tmr_timer8 (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .externalCountPin(pin),
      .cpuGlobalIntEnable(globalInt), .overflowVectorAck(vectorAck), .overflowIrq(irq),
      .sharedPrescale(presc));
   tmr_pin_source i_tmr_pin_source (.clk(clk), .start(start), .pulses(pulses), .pin(pin),
      .busy(busy));
   function automatic logic [7:0] nextRand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitFor(input logic [1:0] what);
      int i;
      for (i = 0; i < 200; i++) begin
         @(negedge clk);
         if (what == 2'h0 && hreadyout === 1'b1) break;
         if (what == 2'h1 && busy === 1'b0) break;
      end
      if (i == 200) begin
         nErrors++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= tmr_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      waitFor(2'h0);
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitFor(2'h0);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
      @(posedge clk);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic overflow();
      bus(1'b1, tmr_pkg::OFF_COUNT, 32'h0000_00FE);
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 5; k++) rdChk(8'(4 * k), 32'h0);
      bus(1'b1, 8'h20, 32'h0000_00FF);
      rdChk(8'h20, 32'h0);
      bus(1'b1, tmr_pkg::OFF_MASK, 32'h0000_00A5);
      rdChk(tmr_pkg::OFF_MASK, 32'h0000_00A5);
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0000_00FF);
      rdChk(tmr_pkg::OFF_CTRL, 32'h0000_0007);
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0);
      repeat (8) begin
         lfsr = nextRand(lfsr);
         bus(1'b1, tmr_pkg::OFF_COUNT, {24'h0, lfsr});
         modelQ.push_back(int'(lfsr));
         rdChk(tmr_pkg::OFF_COUNT, 32'(modelQ.pop_front()));
      end
      repeat (20) @(posedge clk);
      rdChk(tmr_pkg::OFF_COUNT, {24'h0, lfsr});
      bus(1'b1, tmr_pkg::OFF_SFIO, 32'h0000_0001);
      @(posedge clk);
      @(negedge clk);
      check({22'h0, presc}, 32'h0);
      repeat (5) @(posedge clk);
      @(negedge clk);
      check({22'h0, presc}, 32'h0000_0005);
      @(posedge clk);
      rdChk(tmr_pkg::OFF_SFIO, 32'h0);
      for (int c = 1; c <= 5; c++) begin
         n = (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
         bus(1'b1, tmr_pkg::OFF_COUNT, 32'h0);
         bus(1'b1, tmr_pkg::OFF_CTRL, 32'(c));
         repeat (4 * n) @(posedge clk);
         bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0);
         rdChk(tmr_pkg::OFF_CTRL, 32'h0);
         bus(1'b0, tmr_pkg::OFF_COUNT, 32'h0);
         check(32'(rd >= 32'h3 && rd <= 32'h7), 32'h1);
         if (c == 1) begin
            check(rd, 32'(4 * n + 2));
         end
      end
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0000_0001);
      bus(1'b1, tmr_pkg::OFF_COUNT, 32'h0000_0080);
      bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0);
      bus(1'b0, tmr_pkg::OFF_COUNT, 32'h0);
      check(32'(rd >= 32'h80 && rd <= 32'h83), 32'h1);
      check(rd, 32'h0000_0082);
      globalInt <= 1'b1;
      bus(1'b1, tmr_pkg::OFF_MASK, 32'h0000_0001);
      overflow();
      rdChk(tmr_pkg::OFF_FLAGS, 32'h0000_0001);
      bus(1'b0, tmr_pkg::OFF_COUNT, 32'h0);
      check(32'(rd <= 32'h8), 32'h1);
      @(negedge clk);
      check({31'h0, irq}, 32'h1);
      @(posedge clk);
      globalInt <= 1'b0;
      repeat (2) @(negedge clk);
      check({31'h0, irq}, 32'h0);
      @(posedge clk);
      bus(1'b1, tmr_pkg::OFF_FLAGS, 32'h0);
      rdChk(tmr_pkg::OFF_FLAGS, 32'h0000_0001);
      bus(1'b1, tmr_pkg::OFF_FLAGS, 32'h0000_0001);
      rdChk(tmr_pkg::OFF_FLAGS, 32'h0);
      overflow();
      vectorAck <= 1'b1;
      @(posedge clk);
      vectorAck <= 1'b0;
      @(posedge clk);
      rdChk(tmr_pkg::OFF_FLAGS, 32'h0);
      for (int c = 6; c <= 7; c++) begin
         lfsr = nextRand(lfsr);
         expCount = int'(lfsr[3:0]) + 1;
         bus(1'b1, tmr_pkg::OFF_COUNT, 32'h0);
         bus(1'b1, tmr_pkg::OFF_CTRL, 32'(c));
         pulses <= 8'(expCount);
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         waitFor(2'h1);
         repeat (6) @(posedge clk);
         bus(1'b1, tmr_pkg::OFF_CTRL, 32'h0);
         rdChk(tmr_pkg::OFF_COUNT, 32'(expCount));
      end
      tally_and_finish();
   end
endmodule
